/* File: serial_out.sv */
// serializer for two 14-bit sample channels onto one or two lanes each
// assumes samples arrive on i_clk from the converter core; pins are asynchronous
//
// Contract
// - Channel power-down control high powers that channel down; low runs normally.
// - With serial port enabled, mode pins are ignored; register settings apply.
// - Test high replaces samples with fixed pattern 10100110001110, msb first.
// - Dual-lane: alignment 0 offsets lanes by half word; 1 aligns them.
// - Lane-count select 0 gives dual-lane; 1 sends everything on lane 1.
// - One new bit per active lane on each forwarded clock edge.
// - Power-down of both channels holds forwarded clock and frame low.
// - Frame rises at word start and falls at the half-word point; lane 1 words start on rise.
// - Dual-lane, alignment 0: lane 0 words start on frame fall.
// - Lane 1 carries every sample single-lane, every other sample dual-lane.
// - Dual-lane: channel A lane 0 carries the alternate samples.
// - Single-lane: lane 0 outputs are not driven.
// - Power-down: data lanes keep their last level.
// - Dual-lane: channel B lane 0 carries its alternate samples too.
// - Serial port disabled: direct control pins are obeyed.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module serial_out (
  input wire logic i_clk, // 40 MHz system clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic i_link_clk, // link bit clock, one bit per cycle
  input wire logic [serial_out_pkg::ADDR_W-1:0] i_addr, // register address
  input wire logic [31:0] i_wr_data, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rd_data, // read data, cycle after strobe
  input wire logic i_spi_enable, // pin: registers override mode pins
  input wire logic i_power_down_channel_a, // pin: channel a power-down
  input wire logic i_power_down_channel_b, // pin: channel b power-down
  input wire logic i_test, // pin: fixed test pattern
  input wire logic i_word_alignment_select, // pin: 0 half-word offset, 1 aligned
  input wire logic i_lane_count_select, // pin: 0 dual lane, 1 single lane
  input wire logic i_sample_valid, // new sample pair this cycle
  input wire logic [13:0] i_sample_a, // channel a sample
  input wire logic [13:0] i_sample_b, // channel b sample
  output logic o_forwarded_bit_clock, // forwarded clock, bit per edge
  output logic o_frame, // word frame
  output logic o_chan_a_primary_lane, // channel a lane 1
  output logic o_chan_b_primary_lane, // channel b lane 1
  output logic o_chan_a_secondary_lane, // channel a lane 0
  output logic o_chan_a_secondary_lane_oe, // channel a lane 0 drive enable
  output logic o_chan_b_secondary_lane, // channel b lane 0
  output logic o_chan_b_secondary_lane_oe // channel b lane 0 drive enable
);

  // ----------------------------------------
  // pin synchronisers and settings select
  // ----------------------------------------
  serial_out_pkg::ctrl_type pin_meta, pin_sync, ctrl_reg, eff, ctrl_q;
  logic spi_meta, spi_sync;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_meta <= serial_out_pkg::PIN_RESET;
      pin_sync <= serial_out_pkg::PIN_RESET;
      spi_meta <= 1'b0;
      spi_sync <= 1'b0;
    end else if (i_ce) begin
      pin_meta <= {i_power_down_channel_a, i_power_down_channel_b, i_test,
                   i_word_alignment_select, i_lane_count_select};
      pin_sync <= pin_meta;
      spi_meta <= i_spi_enable;
      spi_sync <= spi_meta;
    end
  end

  always_comb begin
    eff = spi_sync ? ctrl_reg : pin_sync;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= serial_out_pkg::CTRL_RESET;
    end else if (i_ce) begin
      ctrl_q <= eff;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic [7:0] drop_cnt;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= serial_out_pkg::CTRL_RESET;
    end else if (i_ce && i_wr && i_addr == serial_out_pkg::CTRL_ADDR) begin
      ctrl_reg <= i_wr_data[4:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_data <= 32'h00000000;
    end else if (i_ce) begin
      o_rd_data <= 32'h00000000;
      if (i_rd && i_addr == serial_out_pkg::CTRL_ADDR) begin
        o_rd_data[4:0] <= ctrl_reg;
      end else if (i_rd && i_addr == serial_out_pkg::STATUS_ADDR) begin
        o_rd_data[4:0] <= ctrl_q;
        o_rd_data[serial_out_pkg::STATUS_DROP_LSB +: 8] <= drop_cnt;
      end
    end
  end

  // ----------------------------------------
  // sample pairing on the system clock
  // ----------------------------------------
  serial_out_pkg::lane_word_type hold, next_pair;
  logic [13:0] word_a, word_b, stage_a, stage_b;
  logic phase, publish, busy, req_tog, ack_meta, ack_sync;

  always_comb begin
    word_a = eff.test_pattern ? serial_out_pkg::TEST_PATTERN : i_sample_a;
    word_b = eff.test_pattern ? serial_out_pkg::TEST_PATTERN : i_sample_b;
    busy = req_tog != ack_sync;
    if (eff.lane_count_select) begin
      // single lane: every sample goes out on lane 1
      next_pair = {word_a, 14'h0000, word_b, 14'h0000};
      publish = i_sample_valid;
    end else begin
      // dual lane: even samples on lane 1, odd samples on lane 0
      next_pair = {stage_a, word_a, stage_b, word_b};
      publish = i_sample_valid && phase;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase <= 1'b0;
      stage_a <= 14'h0000;
      stage_b <= 14'h0000;
    end else if (i_ce && i_sample_valid) begin
      phase <= eff.lane_count_select ? 1'b0 : ~phase;
      if (!phase) begin
        stage_a <= word_a;
        stage_b <= word_b;
      end
    end
  end

  // no buffer: a pair that finds the crossing busy is dropped and counted
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hold <= '0;
      req_tog <= 1'b0;
      drop_cnt <= 8'h00;
    end else if (i_ce && publish) begin
      if (!busy) begin
        hold <= next_pair;
        req_tog <= ~req_tog;
      end else begin
        drop_cnt <= drop_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // crossing into the link domain
  // ----------------------------------------
  logic rst_meta, rst_l, ce_meta, ce_l;
  logic req_meta, req_sync, req_seen;
  serial_out_pkg::ctrl_type ctrl_meta, ctrl_l;
  serial_out_pkg::lane_word_type cur;

  always_ff @(posedge i_link_clk) begin
    rst_meta <= i_rst;
    rst_l <= rst_meta;
    ce_meta <= i_ce;
    ce_l <= ce_meta;
  end

  // settings are quasi-static; a change may tear for one link cycle
  always_ff @(posedge i_link_clk) begin
    if (rst_l) begin
      ctrl_meta <= serial_out_pkg::CTRL_RESET;
      ctrl_l <= serial_out_pkg::CTRL_RESET;
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
      cur <= '0;
    end else if (ce_l) begin
      ctrl_meta <= ctrl_q;
      ctrl_l <= ctrl_meta;
      req_meta <= req_tog;
      req_sync <= req_meta;
      req_seen <= req_sync;
      if (req_sync != req_seen) begin
        cur <= hold;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else if (i_ce) begin
      ack_meta <= req_seen;
      ack_sync <= ack_meta;
    end
  end

  // ----------------------------------------
  // link timing: bit counter, clock, frame
  // ----------------------------------------
  logic [3:0] bit_cnt, nxt_cnt;
  logic both_down, dual, load1, load0;
  logic [1:0] pd_l;

  always_comb begin
    both_down = ctrl_l.power_down_channel_a && ctrl_l.power_down_channel_b;
    pd_l = {ctrl_l.power_down_channel_b, ctrl_l.power_down_channel_a};
    dual = !ctrl_l.lane_count_select;
    nxt_cnt = (bit_cnt == serial_out_pkg::LAST_BIT) ? 4'h0 : bit_cnt + 4'h1;
    load1 = nxt_cnt == 4'h0;
    load0 = dual && (ctrl_l.word_alignment_select ? nxt_cnt == 4'h0
                                                  : nxt_cnt == serial_out_pkg::HALF_WORD);
  end

  always_ff @(posedge i_link_clk) begin
    if (rst_l) begin
      bit_cnt <= serial_out_pkg::LAST_BIT;
      o_forwarded_bit_clock <= 1'b0;
      o_frame <= 1'b0;
    end else if (ce_l) begin
      if (both_down) begin
        bit_cnt <= serial_out_pkg::LAST_BIT;
        o_forwarded_bit_clock <= 1'b0;
        o_frame <= 1'b0;
      end else begin
        bit_cnt <= nxt_cnt;
        o_forwarded_bit_clock <= ~nxt_cnt[0];
        o_frame <= nxt_cnt < serial_out_pkg::HALF_WORD;
      end
    end
  end

  // ----------------------------------------
  // per-channel shift registers
  // ----------------------------------------
  logic [13:0] sh1 [2];
  logic [13:0] sh0 [2];
  logic [13:0] h0 [2];
  logic [13:0] cur_p [2];
  logic [13:0] cur_s [2];

  always_comb begin
    cur_p[0] = cur.chan_a_primary;
    cur_p[1] = cur.chan_b_primary;
    cur_s[0] = cur.chan_a_secondary;
    cur_s[1] = cur.chan_b_secondary;
  end

  // a powered-down channel freezes its shifters so the lanes hold level
  always_ff @(posedge i_link_clk) begin
    if (rst_l) begin
      for (int ch = 0; ch < 2; ch++) begin
        sh1[ch] <= 14'h0000;
        sh0[ch] <= 14'h0000;
        h0[ch] <= 14'h0000;
      end
    end else if (ce_l && !both_down) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!pd_l[ch]) begin
          if (load1) begin
            sh1[ch] <= cur_p[ch];
            h0[ch] <= cur_s[ch];
          end else begin
            sh1[ch] <= {sh1[ch][12:0], 1'b0};
          end
          if (load0) begin
            sh0[ch] <= ctrl_l.word_alignment_select ? cur_s[ch] : h0[ch];
          end else begin
            sh0[ch] <= {sh0[ch][12:0], 1'b0};
          end
        end
      end
    end
  end

  always_comb begin
    o_chan_a_primary_lane = sh1[0][13];
    o_chan_b_primary_lane = sh1[1][13];
    o_chan_a_secondary_lane = sh0[0][13];
    o_chan_b_secondary_lane = sh0[1][13];
  end

  always_ff @(posedge i_link_clk) begin
    if (rst_l) begin
      o_chan_a_secondary_lane_oe <= 1'b0;
      o_chan_b_secondary_lane_oe <= 1'b0;
    end else if (ce_l) begin
      o_chan_a_secondary_lane_oe <= dual;
      o_chan_b_secondary_lane_oe <= dual;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  override_sel_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && spi_sync |=> ctrl_q == $past(ctrl_reg))
    else $error("register settings not applied under port enable");

  test_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce && publish && eff.test_pattern && !busy
    |=> ($past(eff.lane_count_select) ? hold.chan_a_primary : hold.chan_a_secondary) == serial_out_pkg::TEST_PATTERN
    && ($past(eff.lane_count_select) ? hold.chan_b_primary : hold.chan_b_secondary) == serial_out_pkg::TEST_PATTERN)
    else $error("test pattern not substituted");

  bit_clock_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
    ce_l && !both_down |=> o_forwarded_bit_clock != $past(o_forwarded_bit_clock))
    else $error("forwarded clock missed a toggle");

  down_quiet_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
    ce_l && both_down |=> !o_forwarded_bit_clock && !o_frame)
    else $error("clock or frame active in power-down");

  frame_rise_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
    $rose(o_frame) |-> bit_cnt == 4'h0)
    else $error("frame rose off a word start");

  frame_fall_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
    $fell(o_frame) && !both_down |-> bit_cnt == serial_out_pkg::HALF_WORD)
    else $error("frame fell off the half-word point");

  word_load_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
    ce_l && !both_down && !pd_l[0] && bit_cnt == serial_out_pkg::LAST_BIT
    |=> sh1[0] == $past(cur.chan_a_primary))
    else $error("lane 1 word not loaded after bit 13");

  half_offset_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
    ce_l && !both_down && !pd_l[1] && dual && !ctrl_l.word_alignment_select
    && bit_cnt == 4'h6 |=> sh0[1] == $past(h0[1]))
    else $error("lane 0 word not loaded at half word");

  lane_hold_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
    pd_l[0] |=> $stable(o_chan_a_primary_lane) && $stable(o_chan_a_secondary_lane))
    else $error("powered-down lane changed level");

  single_float_a: assert property (@(posedge i_link_clk) disable iff (rst_l)
    ce_l && ctrl_l.lane_count_select |=> !o_chan_a_secondary_lane_oe && !o_chan_b_secondary_lane_oe)
    else $error("lane 0 driven in single-lane mode");

endmodule

`default_nettype wire

/* File: serial_out_pkg.sv */
// constants and carrier types for the dual-channel serial sample output block
// assumes a 40 MHz system clock and a separate free-running link clock
package serial_out_pkg;

  // ----------------------------------------
  // word framing
  // ----------------------------------------
  localparam logic [3:0] LAST_BIT = 4'hD;
  localparam logic [3:0] HALF_WORD = 4'h7;
  localparam logic [13:0] TEST_PATTERN = 14'h298E;

  // ----------------------------------------
  // register port
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [4:0] PIN_RESET = 5'h00;
  localparam int STATUS_DROP_LSB = 8;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic power_down_channel_a;
    logic power_down_channel_b;
    logic test_pattern;
    logic word_alignment_select;
    logic lane_count_select;
  } ctrl_type;

  typedef struct packed {
    logic [13:0] chan_a_primary;
    logic [13:0] chan_a_secondary;
    logic [13:0] chan_b_primary;
    logic [13:0] chan_b_secondary;
  } lane_word_type;

endpackage

/* File: serial_out_rx_model.sv */
// receiving deserializer model for the serial sample output lanes
// assumes lane outputs change on the link clock rising edge; lane 0 may float
`timescale 1ns/1ps
`default_nettype none

module serial_out_rx_model (
  input wire logic i_link_clk, // link clock
  input wire logic i_rst, // reset, active high
  input wire logic i_aligned, // lane 0 words start on frame rise
  input wire logic i_fclk, // forwarded bit clock
  input wire logic i_frame, // word frame
  input wire logic [3:0] i_lanes, // a primary, a secondary, b primary, b secondary
  output serial_out_pkg::lane_word_type o_words, // last complete words
  output logic [7:0] o_errors // framing faults seen
);
  logic pf, pc, have, rise, fall, st0;
  logic [3:0] cyc, n1, n0;
  logic [13:0] s1a, s1b, s0a, s0b;
  assign rise = i_frame & ~pf;
  assign fall = ~i_frame & pf;
  assign st0 = i_aligned ? rise : fall;

  // ----------------------------------------
  // frame timing
  // ----------------------------------------
  // a stalled clock clears history so a restart is not a fault
  always_ff @(posedge i_link_clk) begin
    pf <= i_frame;
    pc <= i_fclk;
    cyc <= rise ? 4'h1 : cyc + 4'h1;
    if (i_rst || i_fclk == pc) begin
      have <= 1'b0;
      if (i_rst) begin
        o_errors <= 8'h00;
      end
    end else if (rise) begin
      have <= 1'b1;
      if (have && cyc != 4'hE) begin
        o_errors <= o_errors + 8'h01;
      end
    end else if (fall && have && cyc != 4'h7) begin
      o_errors <= o_errors + 8'h01;
    end
  end

  // ----------------------------------------
  // word capture
  // ----------------------------------------
  always_ff @(posedge i_link_clk) begin
    s1a <= {s1a[12:0], i_lanes[3]};
    s0a <= {s0a[12:0], i_lanes[2]};
    s1b <= {s1b[12:0], i_lanes[1]};
    s0b <= {s0b[12:0], i_lanes[0]};
    if (i_rst) begin
      n1 <= 4'h0;
      n0 <= 4'h0;
    end else begin
      n1 <= rise ? 4'h1 : (n1 != 4'h0 && n1 != 4'hD) ? n1 + 4'h1 : 4'h0;
      n0 <= st0 ? 4'h1 : (n0 != 4'h0 && n0 != 4'hD) ? n0 + 4'h1 : 4'h0;
      if (n1 == 4'hD && !rise) begin
        o_words.chan_a_primary <= {s1a[12:0], i_lanes[3]};
        o_words.chan_b_primary <= {s1b[12:0], i_lanes[1]};
      end
      if (n0 == 4'hD && !st0) begin
        o_words.chan_a_secondary <= {s0a[12:0], i_lanes[2]};
        o_words.chan_b_secondary <= {s0b[12:0], i_lanes[0]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: serial_out_tb_top.sv */
// self-checking bench for the dual-channel serial sample output block
// assumes the receiver model is compiled before it; no random stimulus
`timescale 1ns/1ps
`default_nettype none

module serial_out_tb_top;
  logic i_clk, i_link_clk, i_rst, wr, rd, sv, spi, aligned;
  logic fclk, frame, a1, b1, a0, b0, a0_oe, b0_oe;
  logic [3:0] addr, snap;
  logic [31:0] wdata, rdata, d;
  logic [13:0] sa, sb;
  logic [7:0] rx_errors;
  serial_out_pkg::ctrl_type pins;
  serial_out_pkg::lane_word_type words;
  wire logic a0_w, b0_w;
  int mismatches, compares;
  int cycles = 0;
  // lane 0 floats when its driver lets go
  assign a0_w = a0_oe ? a0 : 1'bz;
  assign b0_w = b0_oe ? b0 : 1'bz;

  serial_out serial_out_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_link_clk(i_link_clk),
    .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_spi_enable(spi),
    .i_power_down_channel_a(pins.power_down_channel_a), .i_power_down_channel_b(pins.power_down_channel_b),
    .i_test(pins.test_pattern), .i_word_alignment_select(pins.word_alignment_select),
    .i_lane_count_select(pins.lane_count_select), .i_sample_valid(sv), .i_sample_a(sa), .i_sample_b(sb),
    .o_forwarded_bit_clock(fclk), .o_frame(frame), .o_chan_a_primary_lane(a1), .o_chan_b_primary_lane(b1),
    .o_chan_a_secondary_lane(a0), .o_chan_a_secondary_lane_oe(a0_oe), .o_chan_b_secondary_lane(b0),
    .o_chan_b_secondary_lane_oe(b0_oe));

  serial_out_rx_model serial_out_rx_model_inst (.i_link_clk(i_link_clk), .i_rst(i_rst), .i_aligned(aligned),
    .i_fclk(fclk), .i_frame(frame), .i_lanes({a1, a0_w, b1, b0_w}), .o_words(words), .o_errors(rx_errors));

  // ----------------------------------------
  // clocks and timeout
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #1.3;
    forever #3 i_link_clk = ~i_link_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // pairs spaced well apart so none is dropped
  task automatic send(input logic [13:0] a, input logic [13:0] b);
    @(posedge i_clk);
    sa <= a;
    sb <= b;
    sv <= 1'b1;
    @(posedge i_clk);
    sv <= 1'b0;
    repeat (7) @(posedge i_clk);
  endtask
  task automatic set_pins(input logic [4:0] v, input int n);
    @(posedge i_clk);
    pins <= v;
    aligned <= v[1];
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk_words(input logic [13:0] x1, input logic [13:0] x0, input logic [13:0] y1,
      input logic [13:0] y0);
    chk({18'h0, words.chan_a_primary}, {18'h0, x1});
    chk({18'h0, words.chan_a_secondary}, {18'h0, x0});
    chk({18'h0, words.chan_b_primary}, {18'h0, y1});
    chk({18'h0, words.chan_b_secondary}, {18'h0, y0});
  endtask
  task automatic results;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_rst = 1'b1;
    {wr, rd, sv, spi, aligned} = 5'h00;
    addr = 4'h0;
    wdata = 32'h0;
    sa = 14'h0;
    sb = 14'h0;
    pins = 5'h00;
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (6) begin
      send(14'h1234, 14'h2D51);
      send(14'h0ABC, 14'h3F07);
    end
    repeat (40) @(posedge i_clk);
    chk_words(14'h1234, 14'h0ABC, 14'h2D51, 14'h3F07);
    chk({30'h0, a0_oe, b0_oe}, 32'h3);
    set_pins(5'h02, 40);
    chk_words(14'h1234, 14'h0ABC, 14'h2D51, 14'h3F07);
    // the pattern replaces samples at the input, so fresh samples must be sent
    set_pins(5'h04, 10);
    send(14'h1111, 14'h2222);
    send(14'h3333, 14'h0444);
    repeat (40) @(posedge i_clk);
    chk_words(14'h298E, 14'h298E, 14'h298E, 14'h298E);
    set_pins(5'h01, 10); // single lane keeps alignment at 0
    repeat (3) send(14'h1A5C, 14'h05F3);
    repeat (40) @(posedge i_clk);
    chk({18'h0, words.chan_a_primary}, 32'h1A5C);
    chk({18'h0, words.chan_b_primary}, 32'h05F3);
    chk({30'h0, a0_oe, b0_oe}, 32'h0);
    chk({24'h0, rx_errors}, 32'h0);
    set_pins(5'h11, 20);
    snap = {a1, a0, b1, b0};
    repeat (3) send(14'h2AAA, 14'h1555);
    repeat (20) begin
      repeat (3) @(posedge i_clk);
      chk({31'h0, a1}, {31'h0, snap[3]});
    end
    chk({18'h0, words.chan_b_primary}, 32'h1555);
    set_pins(5'h19, 20);
    snap = {a1, a0, b1, b0};
    repeat (20) begin
      repeat (3) @(posedge i_clk);
      chk({26'h0, fclk, frame, a1, a0, b1, b0}, {28'h0, snap});
    end
    @(posedge i_clk);
    spi <= 1'b1;
    reg_wr(serial_out_pkg::CTRL_ADDR, 32'h4);
    reg_rd(serial_out_pkg::CTRL_ADDR, d);
    chk(d, 32'h4);
    repeat (20) @(posedge i_clk);
    reg_rd(serial_out_pkg::STATUS_ADDR, d);
    chk({27'h0, d[4:0]}, 32'h4);
    send(14'h0123, 14'h3210);
    send(14'h2468, 14'h1357);
    repeat (60) @(posedge i_clk);
    chk_words(14'h298E, 14'h298E, 14'h298E, 14'h298E);
    reg_rd(4'h8, d);
    chk(d, 32'h0);
    @(posedge i_clk);
    spi <= 1'b0;
    repeat (20) @(posedge i_clk);
    reg_rd(serial_out_pkg::STATUS_ADDR, d);
    chk({27'h0, d[4:0]}, 32'h19);
    chk({24'h0, d[15:8]}, 32'h0);
    chk({30'h0, fclk, frame}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
